// file: verilog/expander_cfg_pkg.sv
// Register map, field positions, reset values and timing of the config block
`default_nettype none
package expander_cfg_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_MISC      = 8'h10;
	localparam logic [7:0] OFS_LED_EN    = 8'h11;
	localparam logic [7:0] OFS_DEB_TIME  = 8'h12;
	localparam logic [7:0] OFS_DEB_EN    = 8'h13;
	localparam logic [7:0] OFS_KEY_CFG   = 8'h14;
	localparam logic [7:0] OFS_KEY_CODE  = 8'h15;

	// ------------------------------------------------------------------
	// Reset values and write masks
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_MISC      = 8'h00;
	localparam logic [7:0] RST_LED_EN    = 8'h00;
	localparam logic [7:0] RST_DEB_TIME  = 8'h00;
	localparam logic [7:0] RST_DEB_EN    = 8'h00;
	localparam logic [7:0] RST_KEY_CFG   = 8'h00;
	localparam logic [7:0] RST_KEY_CODE  = 8'hFF;
	localparam logic [7:0] DEB_TIME_MASK = 8'h07;
	localparam logic [7:0] KEY_CFG_MASK  = 8'h7F;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int MISC_BANKB_LOG  = 7;
	localparam int MISC_DIV_MSB    = 6;
	localparam int MISC_DIV_LSB    = 4;
	localparam int MISC_BANKA_LOG  = 3;
	localparam int MISC_RSTPIN_FN  = 2;
	localparam int MISC_NO_INC     = 1;
	localparam int MISC_NO_AUTOCLR = 0;
	localparam int DEB_TIME_MSB    = 2;
	localparam int KEY_ROW_MSB     = 6;
	localparam int KEY_ROW_LSB     = 5;
	localparam int KEY_COL_MSB     = 4;
	localparam int KEY_COL_LSB     = 3;
	localparam int KEY_SCAN_MSB    = 2;
	localparam int COL_PIN_BASE    = 4;

	// ------------------------------------------------------------------
	// Timing, in oscillator cycles (times scale with 2 MHz / oscillator_frequency)
	// ------------------------------------------------------------------
	localparam int REF_CLOCK_KHZ    = 2000;
	localparam int DEBOUNCE_BASE_US = 500;
	localparam int SCAN_BASE_US     = 1000;
	localparam int TIMER_W          = 18;
	localparam logic [TIMER_W-1:0] DEBOUNCE_BASE_CYCLES =
		TIMER_W'(DEBOUNCE_BASE_US * REF_CLOCK_KHZ / 1000);
	localparam logic [TIMER_W-1:0] SCAN_BASE_CYCLES =
		TIMER_W'(SCAN_BASE_US * REF_CLOCK_KHZ / 1000);
	localparam logic [1:0] OSC_OFF = 2'h0;

	// ------------------------------------------------------------------
	// Keypad scanner states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SCAN_IDLE = 2'b00,
		SCAN_ROW  = 2'b01,
		SCAN_HOLD = 2'b10
	} scan_state_e;

endpackage
`default_nettype wire

// file: verilog/pin_debouncer.sv
// Per-pin input debounce filter with individual bypass
`timescale 1ns/10ps
`default_nettype none
module pin_debouncer (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  rst_n,
	input  wire logic                                  ce,
	// Control
	input  wire logic                                  active,
	input  wire logic [7:0]                            enable,
	input  wire logic [expander_cfg_pkg::TIMER_W-1:0]  threshold,
	// Data
	input  wire logic [7:0]                            raw,
	output logic      [7:0]                            filtered
);

	// ------------------------------------------------------------------
	// One filter per pin
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_ch
			logic [expander_cfg_pkg::TIMER_W-1:0] cnt_ff;
			logic                                 out_ff;

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cnt_ff <= '0;
					out_ff <= 1'b1;
				end else if (ce) begin
					if (!active || !enable[i]) begin
						// Bypass follows the raw level directly
						cnt_ff <= '0;
						out_ff <= raw[i];
					end else if (raw[i] == out_ff) begin
						cnt_ff <= '0;
					end else if (cnt_ff + 1'b1 >= threshold) begin
						cnt_ff <= '0;
						out_ff <= raw[i];
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
			end

			assign filtered[i] = out_ff;
		end
	endgenerate

endmodule
`default_nettype wire

// file: verilog/expander_cfg.sv
// LED, debounce and keypad configuration bank with keypad scanner
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Divider field zero switches every LED driver off.
// - Nonzero divider N gives LED clock of oscillator_frequency over two to N-1.
// - Misc bit 3 picks linear or logarithmic fade law for bank A.
// - Reset pin low is full reset, or counter restart when bit 2 set.
// - Reset-pin function bit survives the external reset pin.
// - Address increments per byte unless misc bit 1 is set.
// - Bit 0 low lets data reads also clear interrupt source.
// - One LED driver enable bit per pin.
// - Debounce time 0.5ms doubling to 64ms, scaled by oscillator.
// - One debounce enable bit per pin; zero bypasses filter.
// - Row field enables scanning and picks 2, 3 or 4 rows.
// - Column field picks 1 to 4 columns from pin 4 upward.
// - Row scan time 1ms doubling to 128ms, scaled by oscillator.
// - Key code resets to all ones and shows key active low.
// - Key code has one zero at column pin, one at row pin.
// - Reading key code clears it, releases interrupt, resumes scan.
// - Oscillator off stops LED, keypad and debounce functions.
module expander_cfg #(
	parameter logic [expander_cfg_pkg::TIMER_W-1:0] DEBOUNCE_BASE_CYCLES =
		expander_cfg_pkg::DEBOUNCE_BASE_CYCLES,
	parameter logic [expander_cfg_pkg::TIMER_W-1:0] SCAN_BASE_CYCLES =
		expander_cfg_pkg::SCAN_BASE_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Byte-level register access from the serial bus engine
	input  wire logic        bus_start,
	input  wire logic [7:0]  bus_addr,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_rd,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	// Device context
	input  wire logic [1:0]  osc_source,
	input  wire logic        external_reset_pin_n,
	input  wire logic [7:0]  pin_in,
	// LED engine controls
	output logic      [7:0]  led_drive_en,
	output logic             led_engine_tick,
	output logic             bank_a_fade_log,
	output logic             bank_b_fade_log,
	output logic             counter_restart,
	output logic             autoclear_on_data_read,
	// Filtered inputs
	output logic      [7:0]  pin_filtered,
	// Keypad
	output logic      [3:0]  row_drive,
	output logic      [3:0]  row_oe,
	output logic             interrupt_line_n
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [7:0] pin_meta_ff;
	logic [7:0] pin_sync_ff;
	logic       rst_meta_ff;
	logic       rst_sync_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= 8'hFF;
			pin_sync_ff <= 8'hFF;
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= 1'b1;
		end else if (ce) begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
			rst_meta_ff <= external_reset_pin_n;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [7:0] misc_control_ff;
	logic [7:0] led_driver_enable_ff;
	logic [7:0] debounce_time_config_ff;
	logic [7:0] debounce_enable_ff;
	logic [7:0] key_matrix_config_ff;
	logic [7:0] pressed_key_code_ff;
	logic [7:0] ptr_ff;
	logic       soft_por;
	logic       reg_wr;
	logic       key_read;
	logic       osc_on;

	assign osc_on   = (osc_source != expander_cfg_pkg::OSC_OFF);
	assign soft_por = !rst_sync_ff &&
		!misc_control_ff[expander_cfg_pkg::MISC_RSTPIN_FN];
	assign reg_wr   = bus_wr && !bus_start;
	assign key_read = bus_rd && !bus_start &&
		(ptr_ff == expander_cfg_pkg::OFS_KEY_CODE);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			misc_control_ff         <= expander_cfg_pkg::RST_MISC;
			led_driver_enable_ff    <= expander_cfg_pkg::RST_LED_EN;
			debounce_time_config_ff <= expander_cfg_pkg::RST_DEB_TIME;
			debounce_enable_ff      <= expander_cfg_pkg::RST_DEB_EN;
			key_matrix_config_ff    <= expander_cfg_pkg::RST_KEY_CFG;
		end else if (ce) begin
			if (soft_por) begin
				// Function bit kept: only a write or power-on clears it
				misc_control_ff <= (expander_cfg_pkg::RST_MISC &
					~(8'h01 << expander_cfg_pkg::MISC_RSTPIN_FN)) |
					(misc_control_ff &
					(8'h01 << expander_cfg_pkg::MISC_RSTPIN_FN));
				led_driver_enable_ff    <= expander_cfg_pkg::RST_LED_EN;
				debounce_time_config_ff <= expander_cfg_pkg::RST_DEB_TIME;
				debounce_enable_ff      <= expander_cfg_pkg::RST_DEB_EN;
				key_matrix_config_ff    <= expander_cfg_pkg::RST_KEY_CFG;
			end else if (reg_wr) begin
				unique case (ptr_ff)
					expander_cfg_pkg::OFS_MISC:
						misc_control_ff <= bus_wdata;
					expander_cfg_pkg::OFS_LED_EN:
						led_driver_enable_ff <= bus_wdata;
					expander_cfg_pkg::OFS_DEB_TIME:
						debounce_time_config_ff <= bus_wdata &
							expander_cfg_pkg::DEB_TIME_MASK;
					expander_cfg_pkg::OFS_DEB_EN:
						debounce_enable_ff <= bus_wdata;
					expander_cfg_pkg::OFS_KEY_CFG:
						key_matrix_config_ff <= bus_wdata &
							expander_cfg_pkg::KEY_CFG_MASK;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Address pointer and read port
	// ------------------------------------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] rd_data_ff;
	logic       rd_valid_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= 8'h00;
		end else if (ce) begin
			if (bus_start) begin
				ptr_ff <= bus_addr;
			end else if ((bus_wr || bus_rd) &&
				!misc_control_ff[expander_cfg_pkg::MISC_NO_INC]) begin
				ptr_ff <= ptr_ff + 8'h01;
			end
		end
	end

	always_comb begin
		unique case (ptr_ff)
			expander_cfg_pkg::OFS_MISC:     rd_mux = misc_control_ff;
			expander_cfg_pkg::OFS_LED_EN:   rd_mux = led_driver_enable_ff;
			expander_cfg_pkg::OFS_DEB_TIME: rd_mux = debounce_time_config_ff;
			expander_cfg_pkg::OFS_DEB_EN:   rd_mux = debounce_enable_ff;
			expander_cfg_pkg::OFS_KEY_CFG:  rd_mux = key_matrix_config_ff;
			expander_cfg_pkg::OFS_KEY_CODE: rd_mux = pressed_key_code_ff;
			default:                        rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else if (ce) begin
			rd_valid_ff <= bus_rd && !bus_start;
			if (bus_rd && !bus_start) begin
				rd_data_ff <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------------
	// LED clock divider and LED controls
	// ------------------------------------------------------------------
	logic [2:0] div_code;
	logic [6:0] div_span;
	logic [5:0] div_mask;
	logic [5:0] div_cnt_ff;
	logic       led_on;
	logic       led_tick_ff;
	logic [7:0] led_drive_en_ff;
	logic       bank_a_log_ff;
	logic       bank_b_log_ff;
	logic       restart_ff;
	logic       autoclr_ff;

	assign div_code = misc_control_ff[expander_cfg_pkg::MISC_DIV_MSB:
		expander_cfg_pkg::MISC_DIV_LSB];
	assign led_on   = (div_code != 3'h0) && osc_on;
	assign div_span = 7'h01 << (div_code - 3'h1);
	assign div_mask = 6'(div_span - 7'h01);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_ff  <= 6'h00;
			led_tick_ff <= 1'b0;
		end else if (ce) begin
			if (!led_on || !rst_sync_ff) begin
				div_cnt_ff  <= 6'h00;
				led_tick_ff <= 1'b0;
			end else begin
				div_cnt_ff  <= div_cnt_ff + 6'h01;
				led_tick_ff <= ((div_cnt_ff & div_mask) == div_mask);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			led_drive_en_ff <= 8'h00;
			bank_a_log_ff   <= 1'b0;
			bank_b_log_ff   <= 1'b0;
			restart_ff      <= 1'b0;
			autoclr_ff      <= 1'b1;
		end else if (ce) begin
			led_drive_en_ff <= led_on ? led_driver_enable_ff : 8'h00;
			bank_a_log_ff   <=
				misc_control_ff[expander_cfg_pkg::MISC_BANKA_LOG];
			bank_b_log_ff   <=
				misc_control_ff[expander_cfg_pkg::MISC_BANKB_LOG];
			restart_ff      <= !rst_sync_ff;
			autoclr_ff      <=
				!misc_control_ff[expander_cfg_pkg::MISC_NO_AUTOCLR];
		end
	end

	// ------------------------------------------------------------------
	// Debounce filter
	// ------------------------------------------------------------------
	logic [expander_cfg_pkg::TIMER_W-1:0] deb_cycles;
	logic [expander_cfg_pkg::TIMER_W-1:0] scan_cycles;

	assign deb_cycles  = DEBOUNCE_BASE_CYCLES <<
		debounce_time_config_ff[expander_cfg_pkg::DEB_TIME_MSB:0];
	assign scan_cycles = SCAN_BASE_CYCLES <<
		key_matrix_config_ff[expander_cfg_pkg::KEY_SCAN_MSB:0];

	pin_debouncer u_debouncer (
		.clock     (clock),
		.rst_n     (rst_n),
		.ce        (ce),
		.active    (osc_on),
		.enable    (debounce_enable_ff),
		.threshold (deb_cycles),
		.raw       (pin_sync_ff),
		.filtered  (pin_filtered)
	);

	// ------------------------------------------------------------------
	// Keypad scanner
	// ------------------------------------------------------------------
	expander_cfg_pkg::scan_state_e state_ff;
	logic [1:0]                           rows_code;
	logic [1:0]                           cols_code;
	logic [3:0]                           col_mask;
	logic [3:0]                           col_low;
	logic [1:0]                           hit_col;
	logic [1:0]                           row_idx_ff;
	logic [expander_cfg_pkg::TIMER_W-1:0] scan_cnt_ff;
	logic                                 scan_en;
	logic                                 row_end;
	logic [3:0]                           row_drive_ff;
	logic [3:0]                           row_oe_ff;
	logic                                 int_n_ff;

	assign rows_code = key_matrix_config_ff[expander_cfg_pkg::KEY_ROW_MSB:
		expander_cfg_pkg::KEY_ROW_LSB];
	assign cols_code = key_matrix_config_ff[expander_cfg_pkg::KEY_COL_MSB:
		expander_cfg_pkg::KEY_COL_LSB];
	assign scan_en   = (rows_code != 2'h0) && osc_on && !soft_por;
	assign col_mask  = 4'(4'hF >> (2'h3 - cols_code));
	assign col_low   = ~pin_filtered[expander_cfg_pkg::COL_PIN_BASE +: 4] &
		col_mask;
	assign row_end   = (scan_cnt_ff + 1'b1 >= scan_cycles);

	// Lowest sensed column wins when several are low
	always_comb begin
		hit_col = 2'h0;
		for (int c = 3; c >= 0; c--) begin
			if (col_low[c]) begin
				hit_col = 2'(c);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= expander_cfg_pkg::SCAN_IDLE;
			row_idx_ff  <= 2'h0;
			scan_cnt_ff <= '0;
		end else if (ce) begin
			if (!scan_en) begin
				state_ff    <= expander_cfg_pkg::SCAN_IDLE;
				row_idx_ff  <= 2'h0;
				scan_cnt_ff <= '0;
			end else begin
				unique case (state_ff)
					expander_cfg_pkg::SCAN_IDLE: begin
						state_ff    <= expander_cfg_pkg::SCAN_ROW;
						row_idx_ff  <= 2'h0;
						scan_cnt_ff <= '0;
					end
					expander_cfg_pkg::SCAN_ROW: begin
						if (!row_end) begin
							scan_cnt_ff <= scan_cnt_ff + 1'b1;
						end else if (col_low != 4'h0) begin
							state_ff <= expander_cfg_pkg::SCAN_HOLD;
						end else begin
							scan_cnt_ff <= '0;
							row_idx_ff  <= (row_idx_ff == rows_code) ?
								2'h0 : row_idx_ff + 2'h1;
						end
					end
					expander_cfg_pkg::SCAN_HOLD: begin
						if (key_read) begin
							state_ff    <= expander_cfg_pkg::SCAN_ROW;
							row_idx_ff  <= 2'h0;
							scan_cnt_ff <= '0;
						end
					end
					default: state_ff <= expander_cfg_pkg::SCAN_IDLE;
				endcase
			end
		end
	end

	// Capture wins over a read in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pressed_key_code_ff <= expander_cfg_pkg::RST_KEY_CODE;
		end else if (ce) begin
			if (scan_en && state_ff == expander_cfg_pkg::SCAN_ROW &&
				row_end && col_low != 4'h0) begin
				pressed_key_code_ff <= ~((8'h01 << row_idx_ff) |
					(8'h01 << (3'(expander_cfg_pkg::COL_PIN_BASE) +
					{1'b0, hit_col})));
			end else if (key_read || soft_por) begin
				pressed_key_code_ff <= expander_cfg_pkg::RST_KEY_CODE;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			row_drive_ff <= 4'hF;
			row_oe_ff    <= 4'h0;
			int_n_ff     <= 1'b1;
		end else if (ce) begin
			if (scan_en && state_ff == expander_cfg_pkg::SCAN_ROW) begin
				row_drive_ff <= ~(4'h1 << row_idx_ff);
				row_oe_ff    <= 4'(4'hF >> (2'h3 - rows_code));
			end else if (scan_en && state_ff == expander_cfg_pkg::SCAN_HOLD) begin
				row_drive_ff <= 4'hF;
				row_oe_ff    <= 4'(4'hF >> (2'h3 - rows_code));
			end else begin
				row_drive_ff <= 4'hF;
				row_oe_ff    <= 4'h0;
			end
			int_n_ff <= !(scan_en && state_ff == expander_cfg_pkg::SCAN_HOLD &&
				!key_read);
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rd_data                = rd_data_ff;
	assign rd_valid               = rd_valid_ff;
	assign led_drive_en           = led_drive_en_ff;
	assign led_engine_tick        = led_tick_ff;
	assign bank_a_fade_log        = bank_a_log_ff;
	assign bank_b_fade_log        = bank_b_log_ff;
	assign counter_restart        = restart_ff;
	assign autoclear_on_data_read = autoclr_ff;
	assign row_drive              = row_drive_ff;
	assign row_oe                 = row_oe_ff;
	assign interrupt_line_n       = int_n_ff;

endmodule
`default_nettype wire

// file: dv/expander_cfg_chk.sv
// Port-level assertions for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module expander_cfg_chk (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       ce,
	// Register bus
	input wire logic       bus_start,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic       rd_valid,
	// Device context and LED controls
	input wire logic [1:0] osc_source,
	input wire logic       external_reset_pin_n,
	input wire logic [7:0] led_drive_en,
	input wire logic       led_engine_tick,
	input wire logic       bank_a_fade_log,
	input wire logic       bank_b_fade_log,
	input wire logic       counter_restart,
	input wire logic       autoclear_on_data_read,
	// Keypad
	input wire logic [3:0] row_drive,
	input wire logic [3:0] row_oe,
	input wire logic       interrupt_line_n
);
	logic [5:0] pin_hist_ff;
	logic       ext_recent;

	// --------------------------------------------------------------
	// Recent reset pin activity excuses setting changes
	// --------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_hist_ff <= 6'h3F;
		end else begin
			pin_hist_ff <= {pin_hist_ff[4:0], external_reset_pin_n};
		end
	end
	assign ext_recent = (pin_hist_ff != 6'h3F) || !external_reset_pin_n;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_RD_ANSWER: assert property (ce && bus_rd && !bus_start |=> rd_valid)
		else $error("read not answered next cycle");
	AST_RD_CAUSE: assert property (rd_valid |-> $past(bus_rd))
		else $error("read answer without read");
	AST_OSC_OFF: assert property (osc_source == 2'h0 [*3]
		|-> led_drive_en == 8'h00 && !led_engine_tick)
		else $error("LED outputs active with oscillator off");
	AST_ROW_SINGLE: assert property (row_oe != 4'h0
		|-> $countones(~row_drive) <= 1)
		else $error("more than one row driven low");
	AST_INT_HOLD: assert property (!interrupt_line_n && !bus_rd
		&& !$past(bus_rd) && !ext_recent |=> !interrupt_line_n)
		else $error("interrupt released without read");
	AST_HOLD_ROWS: assert property (!interrupt_line_n
		&& !$past(interrupt_line_n) |-> row_drive == 4'hF)
		else $error("scan continues while key held");
	AST_CFG_STEADY: assert property (!$stable({bank_a_fade_log,
		bank_b_fade_log, autoclear_on_data_read})
		|-> $past(bus_wr) || $past(bus_wr, 2) || ext_recent)
		else $error("misc setting changed without write");
	AST_RESTART_ON: assert property (!external_reset_pin_n [*5]
		|-> counter_restart)
		else $error("restart missing while pin low");
	AST_RESTART_OFF: assert property (external_reset_pin_n [*5]
		|-> !counter_restart)
		else $error("restart while pin high");
endmodule

bind expander_cfg expander_cfg_chk u_expander_cfg_chk (
	.clock(clock), .rst_n(rst_n), .ce(ce), .bus_start(bus_start),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .rd_valid(rd_valid),
	.osc_source(osc_source), .external_reset_pin_n(external_reset_pin_n),
	.led_drive_en(led_drive_en), .led_engine_tick(led_engine_tick),
	.bank_a_fade_log(bank_a_fade_log), .bank_b_fade_log(bank_b_fade_log),
	.counter_restart(counter_restart),
	.autoclear_on_data_read(autoclear_on_data_read),
	.row_drive(row_drive), .row_oe(row_oe),
	.interrupt_line_n(interrupt_line_n)
);
`default_nettype wire

// file: dv/keypad_matrix.sv
// Key matrix and pull-ups seen on the expander pins
`timescale 1ns/10ps
`default_nettype none
module keypad_matrix (
	// Scanner rows
	input  wire logic [3:0] row_drive,
	input  wire logic [3:0] row_oe,
	// Key closure and forced low level on pin 7
	input  wire logic       pressed,
	input  wire logic [1:0] key_row,
	input  wire logic [1:0] key_col,
	input  wire logic       pin7_low,
	// Pin levels
	output logic      [7:0] pin_in
);
	logic [3:0] row_lvl;

	// Released rows float up to the pull-up level
	assign row_lvl = row_drive | ~row_oe;
	always_comb begin
		pin_in = {4'hF, row_lvl};
		if (pressed && !row_lvl[key_row]) begin
			pin_in[{1'b1, key_col}] = 1'b0;
		end
		if (pin7_low) begin
			pin_in[7] = 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the configuration bank and keypad scanner
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clock, rst_n, bus_start, bus_wr, bus_rd, rd_valid;
	logic [7:0]  bus_addr, bus_wdata, rd_data, pin_in, led_drive_en;
	logic [7:0]  pin_filtered;
	logic [1:0]  osc_source, key_row, key_col;
	logic [3:0]  row_drive, row_oe;
	logic        ext_pin_n, led_engine_tick, bank_a_fade_log;
	logic        bank_b_fade_log, counter_restart, autoclear_on_data_read;
	logic        interrupt_line_n, pressed, pin7_low, ce;
	logic [7:0]  exp_q[$];
	logic [7:0]  d[4];
	logic [31:0] seed;
	int          num_errors, tests_run, i, k, n;

	expander_cfg #(.DEBOUNCE_BASE_CYCLES(18'h4), .SCAN_BASE_CYCLES(18'h10))
	u_expander_cfg (
		.clock(clock), .rst_n(rst_n), .ce(ce), .bus_start(bus_start),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
		.bus_rd(bus_rd), .rd_data(rd_data), .rd_valid(rd_valid),
		.osc_source(osc_source), .external_reset_pin_n(ext_pin_n),
		.pin_in(pin_in), .led_drive_en(led_drive_en),
		.led_engine_tick(led_engine_tick), .bank_a_fade_log(bank_a_fade_log),
		.bank_b_fade_log(bank_b_fade_log), .counter_restart(counter_restart),
		.autoclear_on_data_read(autoclear_on_data_read),
		.pin_filtered(pin_filtered), .row_drive(row_drive), .row_oe(row_oe),
		.interrupt_line_n(interrupt_line_n)
	);
	keypad_matrix u_keypad_matrix (
		.row_drive(row_drive), .row_oe(row_oe), .pressed(pressed),
		.key_row(key_row), .key_col(key_col), .pin7_low(pin7_low),
		.pin_in(pin_in)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic guard(input int cnt);
		if (cnt >= 300) begin
			num_errors++;
			$display("[FAIL] %0t: wait limit reached", $time);
			results();
		end
	endtask
	// One bus cycle per falling edge; every bus input set once
	task automatic op(input logic s, input logic w, input logic r,
		input logic [7:0] v);
		@(negedge clock);
		bus_start = s;
		bus_wr = w;
		bus_rd = r;
		bus_addr = v;
		bus_wdata = v;
	endtask
	task automatic st(input logic [7:0] a);
		op(1'b1, 1'b0, 1'b0, a);
	endtask
	task automatic wr(input logic [7:0] v);
		op(1'b0, 1'b1, 1'b0, v);
	endtask
	task automatic rd(input logic [7:0] e);
		op(1'b0, 1'b0, 1'b1, 8'h00);
		exp_q.push_back(e);
	endtask
	task automatic idle(input int c);
		repeat (c) op(1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	always @(negedge clock) begin
		if (rd_valid === 1'b1) begin
			chk(rd_data, exp_q.pop_front());
		end
	end

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, bus_start, bus_wr, bus_rd, pressed, pin7_low} = 6'h00;
		ce = 1'b1;
		{bus_addr, bus_wdata} = 16'h0000;
		{osc_source, key_row, key_col, ext_pin_n} = 7'h25;
		{num_errors, tests_run} = 0;
		seed = 32'h8EC075C4;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		st(8'h10);
		for (i = 0; i < 6; i++) rd((i == 5) ? 8'hFF : 8'h00);
		st(8'h11);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			d[i] = seed[7:0] & ((i == 3) ? 8'h9F : 8'hFF);
			wr(d[i]);
		end
		wr(8'h00);
		st(8'h11);
		rd(d[0]);
		rd(d[1] & 8'h07);
		rd(d[2]);
		rd(d[3] & 8'h7F);
		rd(8'hFF);
		st(8'h20);
		wr(8'h55);
		rd(8'h00);
		st(8'h14);
		wr(8'h00);
		st(8'h10);
		wr(8'h8B);
		st(8'h11);
		wr(8'h11);
		wr(8'hA5);
		rd(8'hA5);
		rd(8'hA5);
		idle(2);
		chk({7'h00, autoclear_on_data_read}, 8'h00);
		chk({7'h00, bank_a_fade_log}, 8'h01);
		chk({7'h00, bank_b_fade_log}, 8'h01);
		// Frozen bus cycles must not reach the registers
		ce = 1'b0;
		st(8'h11);
		wr(8'h3C);
		idle(1);
		ce = 1'b1;
		for (k = 1; k < 5; k++) begin
			st(8'h10);
			wr(8'(k << 4));
			idle(3);
			chk(led_drive_en, 8'hA5);
			n = 0;
			while (led_engine_tick !== 1'b1 && n < 300) begin
				idle(1);
				n++;
			end
			guard(n);
			n = 0;
			do begin
				idle(1);
				n++;
			end while (led_engine_tick !== 1'b1 && n < 300);
			guard(n);
			chk(8'(n), 8'(1 << (k - 1)));
		end
		st(8'h10);
		wr(8'h00);
		idle(3);
		chk(led_drive_en, 8'h00);
		n = 0;
		repeat (20) begin
			idle(1);
			n += (led_engine_tick !== 1'b0) ? 1 : 0;
		end
		chk(8'(n), 8'h00);
		st(8'h10);
		wr(8'h10);
		osc_source = 2'h0;
		idle(5);
		chk(led_drive_en, 8'h00);
		osc_source = 2'h2;
		st(8'h10);
		wr(8'h1C);
		ext_pin_n = 1'b0;
		idle(8);
		chk({7'h00, counter_restart}, 8'h01);
		ext_pin_n = 1'b1;
		idle(8);
		st(8'h10);
		rd(8'h1C);
		rd(8'hA5);
		st(8'h10);
		wr(8'h18);
		ext_pin_n = 1'b0;
		idle(8);
		ext_pin_n = 1'b1;
		idle(8);
		st(8'h10);
		rd(8'h00);
		rd(8'h00);
		st(8'h12);
		wr(8'h00);
		wr(8'h00);
		pin7_low = 1'b1;
		idle(4);
		chk({7'h00, pin_filtered[7]}, 8'h00);
		pin7_low = 1'b0;
		st(8'h13);
		wr(8'h80);
		idle(6);
		pin7_low = 1'b1;
		idle(2);
		pin7_low = 1'b0;
		idle(1);
		chk({7'h00, pin_filtered[7]}, 8'h01);
		idle(7);
		chk({7'h00, pin_filtered[7]}, 8'h01);
		pin7_low = 1'b1;
		idle(5);
		chk({7'h00, pin_filtered[7]}, 8'h01);
		idle(1);
		chk({7'h00, pin_filtered[7]}, 8'h00);
		pin7_low = 1'b0;
		chk({4'h0, row_oe}, 8'h00);
		st(8'h13);
		wr(8'hF0);
		wr(8'h78);
		pressed = 1'b1;
		n = 0;
		while (interrupt_line_n !== 1'b0 && n < 300) begin
			idle(1);
			n++;
		end
		guard(n);
		chk(8'(n >= 16), 8'h01);
		chk({4'h0, row_oe}, 8'h0F);
		pressed = 1'b0;
		idle(2);
		st(8'h15);
		rd(8'hBE);
		idle(3);
		chk({7'h00, interrupt_line_n}, 8'h01);
		idle(100);
		st(8'h15);
		rd(8'hFF);
		idle(3);
		chk(8'(exp_q.size()), 8'h00);
		results();
	end
endmodule
`default_nettype wire
